// *** design/cmc_crc_checker.sv ***
// configuration memory crc checker with jtag access to the reference store
module cmc_crc_checker
   import cmc_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic              rst,
   input  wire logic              cfg_valid,
   input  wire logic [1:0]        cfg_kind,
   input  wire logic [WORD_W-1:0] cfg_data,
   output      logic              cfg_ready,
   output      logic              cfg_error,
   output      logic              user_mode,
   input  wire logic              recfg_n,
   input  wire logic              check_en,
   input  wire logic              user_io_out,
   output      logic              crc_error_pin,
   output      logic [CRC_W-1:0]  signature,
   input  wire logic              upset_strobe,
   input  wire logic [ADDR_W-1:0] upset_addr,
   input  wire logic [BIT_W-1:0]  upset_bit,
   input  wire logic              tck,
   input  wire logic              tms,
   input  wire logic              tdi,
   output      logic              tdo,
   output      logic              tdo_oe
);
   cmc_crc_if crc_bus ();

   cmc_crc_step u_step (
      .bus (crc_bus.eng)
   );

   cmc_mode_t          mode_reg;
   logic [CRC_W-1:0]   crc_reg;
   logic [CRC_W-1:0]   ref_reg;
   logic [CRC_W-1:0]   sig_reg;
   logic               ref_hi_reg;
   logic [IDX_W-1:0]   load_cnt_reg;
   logic [IDX_W-1:0]   scan_idx_reg;
   logic [WORD_W-1:0]  cell_mem [0:CELL_WORDS-1];
   logic               excl_mem [0:CELL_WORDS-1];
   logic [PIN_W-1:0]   pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_lvl_reg;
   logic [PIN_W-1:0]   pin_agree;
   logic               tck_rise, tck_fall, recfg_req;
   cmc_tap_t           tap_reg, tap_next;
   logic [IR_W-1:0]    ir_reg, ir_sr_reg;
   logic [CRC_W-1:0]   dr_sr_reg;
   logic               byp_reg;
   logic               ref_sel;
   logic               cfg_take, store_word;
   logic [IDX_W-1:0]   scan_end;
   logic [ADDR_W-1:0]  scan_addr;
   logic               scan_cell, scan_ref_hi, scan_ref_lo;

   // three-stage pin synchronisers; a level counts once stages two and three agree
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_s1_reg  <= PIN_IDLE;
         pin_s2_reg  <= PIN_IDLE;
         pin_s3_reg  <= PIN_IDLE;
         pin_lvl_reg <= PIN_IDLE;
      end else begin
         pin_s1_reg  <= {recfg_n, tdi, tms, tck};
         pin_s2_reg  <= pin_s1_reg;
         pin_s3_reg  <= pin_s2_reg;
         pin_lvl_reg <= (pin_lvl_reg & ~pin_agree) | (pin_s3_reg & pin_agree);
      end
   end

   assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
   assign tck_rise  = pin_agree[PIN_TCK] & pin_s3_reg[PIN_TCK] & ~pin_lvl_reg[PIN_TCK];
   assign tck_fall  = pin_agree[PIN_TCK] & ~pin_s3_reg[PIN_TCK] & pin_lvl_reg[PIN_TCK];
   // a low level on the reconfiguration request holds the checker in configuration
   assign recfg_req = ~pin_lvl_reg[PIN_RECFG];

   // scan walk: covered cells, then the two reference halves, high half first
   assign scan_end    = load_cnt_reg + IDX_W'(1);
   assign scan_addr   = scan_idx_reg[ADDR_W-1:0];
   assign scan_cell   = scan_idx_reg < load_cnt_reg;
   assign scan_ref_hi = scan_idx_reg == load_cnt_reg;
   assign scan_ref_lo = scan_idx_reg == scan_end;

   assign cfg_ready  = (mode_reg == MODE_CFG) && !recfg_req;
   assign cfg_take   = cfg_valid && cfg_ready;
   assign store_word = cfg_take && (cfg_kind == KIND_DATA || cfg_kind == KIND_EXCL) &&
                       (load_cnt_reg < IDX_W'(CELL_WORDS));

   // engine input: frame data while configuring, cells and reference in user mode
   always_comb begin
      crc_bus.crc_cur = crc_reg;
      if (mode_reg == MODE_USER) begin
         if (scan_ref_hi)
            crc_bus.word = ref_reg[CRC_W-1:WORD_W];
         else if (scan_ref_lo)
            crc_bus.word = ref_reg[WORD_W-1:0];
         else
            crc_bus.word = cell_mem[scan_addr];
      end else begin
         crc_bus.word = cfg_data;
      end
   end

   // configuration cell storage; upsets flip single stored bits
   always_ff @(posedge core_clk) begin
      if (store_word) begin
         cell_mem[load_cnt_reg[ADDR_W-1:0]] <= cfg_data;
         excl_mem[load_cnt_reg[ADDR_W-1:0]] <= (cfg_kind == KIND_EXCL);
      end else if (upset_strobe) begin
         cell_mem[upset_addr][upset_bit] <= ~cell_mem[upset_addr][upset_bit];
      end
   end

   // mode, frame check during configuration and background scan in user mode
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_reg     <= MODE_CFG;
         crc_reg      <= CRC_INIT;
         sig_reg      <= '0;
         ref_hi_reg   <= 1'b1;
         load_cnt_reg <= '0;
         scan_idx_reg <= '0;
      end else if (recfg_req) begin
         mode_reg     <= MODE_CFG;
         crc_reg      <= CRC_INIT;
         sig_reg      <= '0;
         ref_hi_reg   <= 1'b1;
         load_cnt_reg <= '0;
         scan_idx_reg <= '0;
      end else if (mode_reg == MODE_CFG) begin
         if (cfg_take) begin
            unique case (cfg_kind)
               KIND_DATA, KIND_EXCL: begin
                  crc_reg <= crc_bus.crc_nxt;
                  if (store_word)
                     load_cnt_reg <= load_cnt_reg + IDX_W'(1);
               end
               KIND_FCHK: begin
                  crc_reg <= CRC_INIT;
                  // the first mismatching frame ends configuration until a reconfiguration request
                  if (cfg_data != crc_reg[WORD_W-1:0])
                     mode_reg <= MODE_HALT;
               end
               KIND_REF: begin
                  ref_hi_reg <= ~ref_hi_reg;
                  if (!ref_hi_reg) begin
                     mode_reg     <= MODE_USER;
                     crc_reg      <= CRC_INIT;
                     scan_idx_reg <= '0;
                  end
               end
            endcase
         end
      end else if (mode_reg == MODE_USER) begin
         // residue over cells followed by the reference is zero when intact
         if (scan_ref_lo) begin
            sig_reg      <= crc_bus.crc_nxt;
            crc_reg      <= CRC_INIT;
            scan_idx_reg <= '0;
         end else begin
            if (!scan_cell || !excl_mem[scan_addr])
               crc_reg <= crc_bus.crc_nxt;
            scan_idx_reg <= scan_idx_reg + IDX_W'(1);
         end
      end
   end

   // reference store: loaded from the bitstream, or replaced over jtag
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ref_reg <= REF_RESET;
      end else if (cfg_take && cfg_kind == KIND_REF && mode_reg == MODE_CFG) begin
         if (ref_hi_reg)
            ref_reg[CRC_W-1:WORD_W] <= cfg_data;
         else
            ref_reg[WORD_W-1:0] <= cfg_data;
      end else if (tck_rise && tap_reg == TAP_UPD_DR && ref_sel) begin
         ref_reg <= dr_sr_reg;
      end
   end

   // status outputs; the pin falls back to user io when checking is off
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg_error     <= 1'b0;
         crc_error_pin <= 1'b0;
      end else begin
         cfg_error <= (mode_reg == MODE_HALT);
         if (!check_en)
            crc_error_pin <= user_io_out;
         else
            crc_error_pin <= (mode_reg == MODE_USER) && (sig_reg != '0);
      end
   end

   assign signature = sig_reg;
   assign user_mode = (mode_reg == MODE_USER);

   // the load instruction only reaches the store while in user mode
   assign ref_sel = (ir_reg == IR_LOAD_REF) && (mode_reg == MODE_USER);

   // tap controller state walk on tms
   always_comb begin
      unique case (tap_reg)
         TAP_RESET:  tap_next = pin_lvl_reg[PIN_TMS] ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   tap_next = pin_lvl_reg[PIN_TMS] ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tap_next = pin_lvl_reg[PIN_TMS] ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_next = pin_lvl_reg[PIN_TMS] ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  tap_next = pin_lvl_reg[PIN_TMS] ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tap_next = pin_lvl_reg[PIN_TMS] ? TAP_UPD_DR : TAP_PAU_DR;
         TAP_PAU_DR: tap_next = pin_lvl_reg[PIN_TMS] ? TAP_EX2_DR : TAP_PAU_DR;
         TAP_EX2_DR: tap_next = pin_lvl_reg[PIN_TMS] ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: tap_next = pin_lvl_reg[PIN_TMS] ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: tap_next = pin_lvl_reg[PIN_TMS] ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: tap_next = pin_lvl_reg[PIN_TMS] ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  tap_next = pin_lvl_reg[PIN_TMS] ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tap_next = pin_lvl_reg[PIN_TMS] ? TAP_UPD_IR : TAP_PAU_IR;
         TAP_PAU_IR: tap_next = pin_lvl_reg[PIN_TMS] ? TAP_EX2_IR : TAP_PAU_IR;
         TAP_EX2_IR: tap_next = pin_lvl_reg[PIN_TMS] ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: tap_next = pin_lvl_reg[PIN_TMS] ? TAP_SEL_DR : TAP_IDLE;
      endcase
   end

   // tap state and instruction register, advanced on each rising tck
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tap_reg   <= TAP_RESET;
         ir_reg    <= IR_BYPASS;
         ir_sr_reg <= IR_CAPTURE;
      end else if (tck_rise) begin
         tap_reg <= tap_next;
         unique case (tap_reg)
            TAP_RESET:  ir_reg    <= IR_BYPASS;
            TAP_CAP_IR: ir_sr_reg <= IR_CAPTURE;
            TAP_SH_IR:  ir_sr_reg <= {pin_lvl_reg[PIN_TDI], ir_sr_reg[IR_W-1:1]};
            TAP_UPD_IR: ir_reg    <= ir_sr_reg;
            default:    ir_reg    <= ir_reg;
         endcase
      end
   end

   // data registers: reference shadow when selected, otherwise one-bit bypass
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dr_sr_reg <= '0;
         byp_reg   <= 1'b0;
      end else if (tck_rise) begin
         if (tap_reg == TAP_CAP_DR) begin
            dr_sr_reg <= ref_reg;
            byp_reg   <= 1'b0;
         end else if (tap_reg == TAP_SH_DR) begin
            if (ref_sel)
               dr_sr_reg <= {pin_lvl_reg[PIN_TDI], dr_sr_reg[CRC_W-1:1]};
            byp_reg <= pin_lvl_reg[PIN_TDI];
         end
      end
   end

   // tdo changes on the falling tck so the tester samples a settled bit
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe <= (tap_reg == TAP_SH_DR) || (tap_reg == TAP_SH_IR);
         if (tap_reg == TAP_SH_IR)
            tdo <= ir_sr_reg[0];
         else if (ref_sel)
            tdo <= dr_sr_reg[0];
         else
            tdo <= byp_reg;
      end
   end
endmodule

// *** design/cmc_crc_step.sv ***
// one 16-bit word step of the 32-bit crc, msb first
module cmc_crc_step
   import cmc_pkg::*;
(
   cmc_crc_if.eng      bus
);
   logic [CRC_W-1:0] chain [0:WORD_W];

   assign chain[0] = bus.crc_cur;

   // one shift per data bit, msb of the word first, no reflection
   genvar i;
   generate
      for (i = 0; i < WORD_W; i++) begin : g_bit
         logic fb;
         assign fb           = chain[i][CRC_W-1] ^ bus.word[WORD_W-1-i];
         assign chain[i + 1] = {chain[i][CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
      end
   endgenerate

   assign bus.crc_nxt = chain[WORD_W];
endmodule

// *** inc/cmc_crc_if.sv ***
// carrier between the checker and its crc step engine
interface cmc_crc_if;
   import cmc_pkg::*;
   logic [CRC_W-1:0]  crc_cur;
   logic [WORD_W-1:0] word;
   logic [CRC_W-1:0]  crc_nxt;
   modport src (output crc_cur, output word, input crc_nxt);
   modport eng (input crc_cur, input word, output crc_nxt);
endinterface

// *** inc/cmc_pkg.sv ***
// constants and types of the configuration memory crc checker
package cmc_pkg;
   localparam int          CRC_W        = 32;
   localparam int          WORD_W       = 16;
   localparam int          CELL_WORDS   = 64;
   localparam int          ADDR_W       = 6;
   localparam int          IDX_W        = 7;
   localparam int          BIT_W        = 4;
   localparam int          IR_W         = 10;
   localparam int          PIN_W        = 4;
   localparam logic [31:0] CRC_POLY     = 32'h04C1_1DB7;
   localparam logic [31:0] CRC_INIT     = 32'hFFFF_FFFF;
   localparam logic [31:0] REF_RESET    = 32'h0000_0000;
   localparam logic [9:0]  IR_LOAD_REF  = 10'h015;
   localparam logic [9:0]  IR_BYPASS    = 10'h3FF;
   localparam logic [9:0]  IR_CAPTURE   = 10'h001;
   // synchronised pin vector: {recfg_n, tdi, tms, tck}
   localparam int          PIN_TCK      = 0;
   localparam int          PIN_TMS      = 1;
   localparam int          PIN_TDI      = 2;
   localparam int          PIN_RECFG    = 3;
   localparam logic [3:0]  PIN_IDLE     = 4'hE;

   typedef enum logic [1:0] {
      KIND_DATA = 2'b00,
      KIND_EXCL = 2'b01,
      KIND_FCHK = 2'b10,
      KIND_REF  = 2'b11
   } cmc_kind_t;

   typedef enum logic [1:0] {
      MODE_CFG  = 2'b00,
      MODE_HALT = 2'b01,
      MODE_USER = 2'b10
   } cmc_mode_t;

   typedef enum logic [3:0] {
      TAP_RESET   = 4'h0, TAP_IDLE    = 4'h1, TAP_SEL_DR  = 4'h2, TAP_CAP_DR  = 4'h3,
      TAP_SH_DR   = 4'h4, TAP_EX1_DR  = 4'h5, TAP_PAU_DR  = 4'h6, TAP_EX2_DR  = 4'h7,
      TAP_UPD_DR  = 4'h8, TAP_SEL_IR  = 4'h9, TAP_CAP_IR  = 4'hA, TAP_SH_IR   = 4'hB,
      TAP_EX1_IR  = 4'hC, TAP_PAU_IR  = 4'hD, TAP_EX2_IR  = 4'hE, TAP_UPD_IR  = 4'hF
   } cmc_tap_t;
endpackage

// *** testbench/cmc_crc_checker_assertions.sv ***
// concurrent checks on the crc checker ports
module cmc_chk
   import cmc_pkg::*;
(
   input wire logic             core_clk,
   input wire logic             rst,
   input wire logic             cfg_ready,
   input wire logic             cfg_error,
   input wire logic             user_mode,
   input wire logic             recfg_n,
   input wire logic             check_en,
   input wire logic             user_io_out,
   input wire logic             crc_error_pin,
   input wire logic [CRC_W-1:0] signature,
   input wire logic             tck,
   input wire logic             tdo
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // the pin reports the last finished scan one clock late
   a_pin_follows_sig: assert property (
      user_mode && $past(user_mode) && $past(check_en)
      |-> crc_error_pin == ($past(signature) != 32'h0000_0000))
      else $error("error pin disagrees with signature");
   // checking disabled hands the pin to user logic
   a_pin_mirror_io: assert property (!$past(check_en) |-> crc_error_pin == $past(user_io_out))
      else $error("pin does not follow user data");
   // no error report outside user mode
   a_pin_off_cfg: assert property (
      !user_mode && !$past(user_mode) && $past(check_en) |-> !crc_error_pin)
      else $error("pin high outside user mode");
   a_halt_blocks_cfg: assert property (cfg_error |-> !cfg_ready && !user_mode)
      else $error("configuration goes on after mismatch");
   a_user_blocks_cfg: assert property (user_mode |-> !cfg_ready && !cfg_error)
      else $error("config stream open in user mode");
   // a held request clears mode and result
   a_recfg_clears: assert property (
      (!recfg_n) [*8] |-> !user_mode && !cfg_ready && !cfg_error && signature == 32'h0000_0000)
      else $error("reconfiguration request ignored");
   // tdo may only move after a falling tck, well before the next rise
   a_tdo_on_fall: assert property ($changed(tdo) |-> !tck && !$past(tck, 2))
      else $error("tdo moved off the falling edge");
   // a new signature holds for at least the next eight clocks
   a_sig_scan_hold: assert property (
      $changed(signature) && user_mode |=> $stable(signature) [*8])
      else $error("signature changed mid scan");
endmodule

bind cmc_crc_checker cmc_chk i_cmc_chk (.core_clk, .rst, .cfg_ready, .cfg_error, .user_mode,
   .recfg_n, .check_en, .user_io_out, .crc_error_pin, .signature, .tck, .tdo);

// *** testbench/cmc_crc_checker_test.sv ***
// self-checking bench for the configuration memory crc checker
module cmc_crc_checker_test import cmc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic              core_clk = 1'b0, rst = 1'b1, cfg_valid = 1'b0, check_en = 1'b1;
   logic              user_io_out = 1'b0, upset_strobe = 1'b0;
   logic              cfg_ready, cfg_error, user_mode, recfg_n, crc_error_pin;
   logic              tck, tms, tdi, tdo, tdo_oe;
   logic [1:0]        cfg_kind = 2'h0;
   logic [WORD_W-1:0] cfg_data = 16'h0000;
   logic [WORD_W-1:0] cells [64];
   logic [CRC_W-1:0]  signature, good_ref, got;
   logic [ADDR_W-1:0] upset_addr = 6'h00;
   logic [BIT_W-1:0]  upset_bit = 4'h0;
   int                error_cnt = 0, total_checks = 0;

   cmc_crc_checker i_cmc_crc_checker (.core_clk, .rst, .cfg_valid, .cfg_kind, .cfg_data,
      .cfg_ready, .cfg_error, .user_mode, .recfg_n, .check_en, .user_io_out, .crc_error_pin,
      .signature, .upset_strobe, .upset_addr, .upset_bit, .tck, .tms, .tdi, .tdo, .tdo_oe);
   cmc_tester_model i_cmc_tester_model (.clk(core_clk), .tdo, .tck, .tms, .tdi, .recfg_n);

   always #12.5 core_clk = ~core_clk;

   // one word into the crc, msb first, no reflection
   function automatic logic [31:0] step(logic [31:0] c, logic [15:0] w);
      for (int i = 15; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? CRC_POLY : 32'h0);
      return c;
   endfunction
   // expected signature: covered cells then the reference, zero when intact
   function automatic logic [31:0] scan(logic [31:0] r);
      logic [31:0] c = CRC_INIT;
      for (int i = 0; i < 64; i++) if (i % 8 != 7) c = step(c, cells[i]);
      c = step(c, r[31:16]);
      return step(c, r[15:0]);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic send(input logic [1:0] k, input logic [15:0] d);
      @(negedge core_clk);
      chk(cfg_ready, 1'b1);
      cfg_valid = 1'b1;
      cfg_kind  = k;
      cfg_data  = d;
   endtask
   // frames of eight words, the last one excluded; a bad run stops after frame 0
   task automatic configure(input logic bad);
      logic [31:0] fc;
      fc       = CRC_INIT;
      good_ref = CRC_INIT;
      for (int i = 0; i < (bad ? 8 : 64); i++) begin
         cells[i] = 16'h5A00 + 16'(i * 16'h0131);
         send((i % 8 == 7) ? KIND_EXCL : KIND_DATA, cells[i]);
         fc = step(fc, cells[i]);
         if (i % 8 != 7) good_ref = step(good_ref, cells[i]);
         if (i % 8 == 7) begin
            send(KIND_FCHK, fc[15:0] ^ {15'h0, bad});
            fc = CRC_INIT;
         end
      end
      if (!bad) send(KIND_REF, good_ref[31:16]);
      if (!bad) send(KIND_REF, good_ref[15:0]);
      @(negedge core_clk);
      cfg_valid = 1'b0;
   endtask
   // flip one cell, then wait past two full scans
   task automatic upset(input int a, input int b);
      @(negedge core_clk);
      upset_strobe = 1'b1;
      upset_addr   = a[5:0];
      upset_bit    = b[3:0];
      cells[a][b]  = ~cells[a][b];
      @(negedge core_clk);
      upset_strobe = 1'b0;
      repeat (140) @(negedge core_clk);
   endtask
   task automatic check_scan(input logic [31:0] r);
      chk(signature, scan(r));
      chk(crc_error_pin, scan(r) != 32'h0);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // good stream: user mode follows and the intact array scans to zero
   task automatic scn_good_config();
      configure(1'b0);
      repeat (3) @(negedge core_clk);
      chk(user_mode, 1'b1);
      repeat (140) @(negedge core_clk);
      check_scan(good_ref);
   endtask
   // an excluded cell goes unseen, a covered one flags until flipped back
   task automatic scn_upsets();
      upset(7, 3);
      check_scan(good_ref);
      upset(12, 5);
      check_scan(good_ref);
      upset(12, 5);
      check_scan(good_ref);
   endtask
   // read the good value out while planting a bad one, then put it back
   task automatic scn_inject();
      i_cmc_tester_model.swap_ref(32'h0BAD_C0DE, got);
      chk(got, good_ref);
      chk(tdo_oe, 1'b0);
      repeat (140) @(negedge core_clk);
      check_scan(32'h0BAD_C0DE);
      i_cmc_tester_model.swap_ref(good_ref, got);
      chk(got, 32'h0BAD_C0DE);
      repeat (140) @(negedge core_clk);
      check_scan(good_ref);
   endtask
   // with checking off the pin carries user data
   task automatic scn_pin_disable();
      check_en    = 1'b0;
      user_io_out = 1'b1;
      repeat (3) @(negedge core_clk);
      chk(crc_error_pin, 1'b1);
      check_en = 1'b1;
   endtask
   // reconfigure, a bad frame halts, and the load then acts as bypass
   task automatic scn_reconfig_bad();
      i_cmc_tester_model.reconfigure();
      chk(user_mode, 1'b0);
      repeat (6) @(negedge core_clk);
      chk(cfg_ready, 1'b1);
      configure(1'b1);
      repeat (3) @(negedge core_clk);
      chk(cfg_error, 1'b1);
      chk(cfg_ready, 1'b0);
      // outside user mode the load falls back to the one-bit bypass path
      i_cmc_tester_model.swap_ref(32'h0000_00FF, got);
      chk(got, 32'h0000_01FE);
   endtask

   initial begin
      repeat (12) @(negedge core_clk);
      rst = 1'b0;
      scn_good_config();
      scn_upsets();
      scn_inject();
      scn_pin_disable();
      scn_reconfig_bad();
      final_report();
   end

   // about five times the expected run; a hang counts as a mismatch
   initial begin
      #400_000;
      error_cnt++;
      final_report();
   end
endmodule

// *** testbench/cmc_tester_model.sv ***
// boundary-scan tester and system monitor acting on the checker pins
module cmc_tester_model
   import cmc_pkg::*;
(
   input  wire logic clk,
   input  wire logic tdo,
   output      logic tck,
   output      logic tms,
   output      logic tdi,
   output      logic recfg_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // tdi idles high like a pulled-up line, tck stands still between scans
   initial begin
      tck     = 1'b0;
      tms     = 1'b1;
      tdi     = 1'b1;
      recfg_n = 1'b1;
   end
   // one tck period; halves of six clocks leave room for the pin synchronisers
   task automatic tick(input logic m, input logic d, output logic q);
      tck = 1'b0;
      tms = m;
      tdi = d;
      repeat (6) @(negedge clk);
      q   = tdo;
      tck = 1'b1;
      repeat (6) @(negedge clk);
   endtask
   // reset tap, load the reference instruction, swap 32 bits through the store
   task automatic swap_ref(input logic [31:0] din, output logic [31:0] dout);
      logic q;
      @(negedge clk);
      for (int i = 0; i < 6; i++) tick(i < 5, 1'b1, q);
      for (int i = 0; i < 4; i++) tick(i < 2, 1'b1, q);
      for (int i = 0; i < 10; i++) tick(i == 9, IR_LOAD_REF[i], q);
      for (int i = 0; i < 4; i++) tick(i < 2, 1'b1, q);
      for (int i = 0; i < 32; i++) tick(i == 31, din[i], dout[i]);
      for (int i = 0; i < 2; i++) tick(i == 0, 1'b1, q);
   endtask
   // system side answer to an upset: pulse the request low
   task automatic reconfigure();
      @(negedge clk);
      recfg_n = 1'b0;
      repeat (12) @(negedge clk);
      recfg_n = 1'b1;
   endtask
endmodule
